// >>> logic/char_buffer_io_channel.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1 - Clear resets address, direction, counter and clock detectors.
// RQ2 - Setup loads unit address from instruction bits 19 to 23.
// RQ3 - Direction bit from instruction bit 18: high output, low input.
// RQ4 - Counter preset at setup, or reloaded at pulse 24 on word load.
// RQ5 - Counter decrements on precess at pulse 0; cleared in window 22-17.
// RQ6 - Clock detect samples unit clock in window 22-17 without pending precess.
// RQ7 - Precess detect sets at pulse 0 after clock seen then removed.
// RQ8 - Precess control set at 24 if pending and allowed, reset next 0/24.
// RQ9 - Precessing shifts bits between character and word registers.
// RQ10 - Interlock low means word full or empty and blocks precessing.
// RQ11 - Word load comes from processor path or interlace cycle.
// RQ12 - Halt enable sets only once characters are moving; code also sets it at setup with the output direction bit.
// RQ13 - External halt sets halt at 24; only clear resets it.
// RQ14 - Error sets on parity failure, tape failure or late service.
// RQ15 - Participation flag marks the buffer as using memory interlace.
// RQ16 - Time-share request when word ready, active, no halt, interlace on.
// RQ17 - Time-share flag true exactly during granted memory cycles; code sets it one pulse after memory_grant, and only with participate.
// RQ18 - Serial write bit feeds the word register from character and fill.
// RQ19 - Recirculated bit equals serial write bit delayed 24 pulse times.
// RQ20 - Character buffer has six data bits plus a parity bit.
// RQ21 - Odd character parity; other counts on input are errors.
// RQ22 - Service interrupt when word full or empty and enabled.
// RQ23 - Terminate interrupt when halted with interlock low and enabled.
// RQ24 - Everything steps on the pulse clock from a free pulse counter; the unit data, parity, halt and tape lines are first latched on unit_clk.
// RQ25 - Manual start fills the counter and starts a precess at pulse 0.
module char_buffer_io_channel (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic unit_clk,
    input wire chbuf_pkg::unit_in_t unit_in,
    input wire logic buffer_clear_cmd,
    input wire logic buffer_setup,
    input wire logic [23:0] instr_bits,
    input wire logic word_xfer_cmd,
    input wire logic [23:0] accum_word,
    input wire logic interlace_on,
    input wire logic participate_set,
    input wire logic memory_grant,
    input wire logic irq_enable,
    input wire logic manual_fill_switch,
    input wire logic manual_start_switch,
    input wire logic no_parity_input,
    output logic [23:0] word_out,
    output logic [5:0] char_out,
    output logic char_parity_out,
    output logic recirculated_bit,
    output logic timeshare_req,
    output logic memory_grant_flag,
    output logic service_irq,
    output logic terminate_irq,
    output chbuf_pkg::status_t status
);
    import chbuf_pkg::*;

    // Link-side capture: unit lines are stable per character, so data is
    // latched on the unit clock and the levels cross with two flops.
    logic [6:0] link_char;
    logic link_halt;
    logic link_gap;
    logic link_terr;
    always_ff @(posedge unit_clk or negedge resetn) begin
        if (!resetn) begin
            link_char <= 7'h00;
            link_halt <= 1'b0;
            link_gap <= 1'b0;
            link_terr <= 1'b0;
        end else begin
            link_char <= {unit_in.data, unit_in.parity};
            link_halt <= unit_in.halt;
            link_gap <= unit_in.tape_gap;
            link_terr <= unit_in.tape_error;
        end
    end

    logic [10:0] sync1;
    logic [10:0] sync2;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync1 <= 11'h000;
            sync2 <= 11'h000;
        end else begin
            sync1 <= {link_char, link_halt, link_gap, link_terr, unit_in.clk};
            sync2 <= sync1;
        end
    end
    wire [5:0] in_data = sync2[10:5];
    wire in_parity = sync2[4];
    wire halt_req = sync2[3];
    wire tape_gap = sync2[2];
    wire tape_err = sync2[1];
    wire char_clk = sync2[0];

    // RQ24 pulse counter
    // It counts down, so a precess started at pulse 24 runs to pulse 0.
    logic [4:0] pulse;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pulse <= T0;
        end else begin
            pulse <= (pulse == T0) ? PULSE_LAST : pulse - 5'h01;
        end
    end
    wire t0 = pulse == T0;
    wire t24 = pulse == T24;
    wire tp = pulse == TP;
    wire t_late = pulse >= T17 && pulse <= T22;
    wire t_early = pulse <= T5;

    logic [4:0] unit_address;
    logic direction_out;
    logic char_count_lo;
    logic char_count_hi;
    logic clock_detect;
    logic precess_detect;
    logic precess_control;
    logic interlock_flag;
    logic halt_flag;
    logic halt_enable;
    logic error;
    logic participate;
    logic serial_write_bit;
    logic [5:0] char_bits;
    logic parity_bit;
    logic [23:0] delay_line;
    logic [23:0] word_reg;

    // RQ1 clear term
    wire buffer_clear = buffer_clear_cmd
        || (halt_flag && !interlock_flag && t0)
        || (manual_start_switch && t_early);
    // RQ11 word load
    wire word_load = (word_xfer_cmd && !memory_grant_flag)
        || (participate && memory_grant_flag);
    wire reader = unit_address == READER_ADDR && !direction_out;
    wire capture = !direction_out && clock_detect && !precess_detect;
    // RQ21 odd parity check
    wire parity_ok = ^{parity_bit, char_bits} == 1'b1;
    wire blank_char = char_bits == 6'h00 && !parity_bit;

    // RQ2 address load
    // RQ3 direction load
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            unit_address <= 5'h00;
            direction_out <= 1'b0;
        end else if (buffer_clear) begin
            unit_address <= 5'h00;
            direction_out <= 1'b0;
        end else if (buffer_setup) begin
            unit_address <= instr_bits[ADDR_LSB+:5];
            direction_out <= instr_bits[DIR_BIT];
        end else if (manual_fill_switch) begin
            unit_address <= READER_ADDR;
        end
    end

    // RQ4 counter load
    // RQ5 counter step
    // RQ25 manual start fill
    wire cnt_clear = buffer_clear && t_late;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            char_count_lo <= 1'b0;
            char_count_hi <= 1'b0;
        end else if (manual_start_switch) begin
            {char_count_hi, char_count_lo} <= CNT_FULL;
        end else if (cnt_clear) begin
            {char_count_hi, char_count_lo} <= 2'h0;
        end else if (buffer_setup) begin
            char_count_hi <= instr_bits[CNT_HI_BIT];
            char_count_lo <= instr_bits[CNT_LO_BIT];
        end else if (word_load && t24) begin
            {char_count_hi, char_count_lo} <= CNT_FULL;
        end else if (precess_control && t0
                     && {char_count_hi, char_count_lo} != 2'h0) begin
            {char_count_hi, char_count_lo} <=
                {char_count_hi, char_count_lo} - 2'h1;
        end
    end

    // RQ6 clock detect
    // RQ7 precess detect
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            clock_detect <= 1'b0;
            precess_detect <= 1'b0;
        end else if (buffer_clear) begin
            clock_detect <= 1'b0;
            precess_detect <= 1'b0;
        end else begin
            if (!precess_detect && char_clk && t_late) begin
                clock_detect <= 1'b1;
            end else if (precess_detect && t0) begin
                clock_detect <= 1'b0;
            end
            if (!precess_detect && clock_detect && !char_clk && t0) begin
                precess_detect <= 1'b1;
            end else if (buffer_setup && instr_bits[PRECESS_BIT]
                         && instr_bits[DIR_BIT]) begin
                precess_detect <= 1'b1;
            end else if (precess_control && t0) begin
                precess_detect <= 1'b0;
            end
        end
    end

    // RQ8 precess control
    // RQ10 interlock gate
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            precess_control <= 1'b0;
        end else if (precess_control && (t0 || t24)) begin
            precess_control <= 1'b0;
        end else if ((precess_detect && interlock_flag && t24)
                     || (halt_flag && t24)
                     || ((buffer_setup || manual_start_switch) && t0)) begin
            precess_control <= 1'b1;
        end
    end

    // RQ10 interlock flag
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            interlock_flag <= 1'b0;
        end else if ((buffer_clear && !halt_flag)
                     || (word_load && t_early && !precess_control)) begin
            interlock_flag <= 1'b1;
        end else if ((precess_control && t_late
                      && {char_count_hi, char_count_lo} == 2'h0)
                     || (buffer_setup && instr_bits[DIR_BIT])
                     || (!direction_out && halt_enable && tape_gap
                         && !char_count_lo && t_late)) begin
            interlock_flag <= 1'b0;
        end
    end

    // RQ13 halt flag
    // RQ12 halt enable
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            halt_flag <= 1'b0;
            halt_enable <= 1'b0;
        end else if (buffer_clear_cmd) begin
            halt_flag <= 1'b0;
            halt_enable <= 1'b0;
        end else begin
            if (t24 && (halt_req
                || (reader && blank_char && precess_detect))) begin
                halt_flag <= 1'b1;
            end
            if ((!direction_out && clock_detect && !char_count_hi)
                || (buffer_setup && instr_bits[DIR_BIT])) begin
                halt_enable <= 1'b1;
            end
        end
    end

    // RQ14 error flag
    // Parity is judged at the pulse that starts the precess, while the
    // captured character is still whole and not yet shifted.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            error <= 1'b0;
        end else if ((!direction_out && precess_detect && !precess_control
                      && t24 && !halt_flag && !no_parity_input && !parity_ok)
                     || tape_err
                     || (halt_enable && precess_detect && !clock_detect
                         && char_clk && tp && !interlock_flag)) begin
            error <= 1'b1;
        end else if (buffer_clear && !halt_flag) begin
            error <= 1'b0;
        end
    end

    // RQ15 interlace participation
    // RQ17 grant flag
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            participate <= 1'b0;
            memory_grant_flag <= 1'b0;
        end else begin
            participate <= buffer_clear_cmd ? 1'b0
                         : (participate_set ? 1'b1 : participate);
            memory_grant_flag <= memory_grant && participate;
        end
    end

    // RQ9 character shift
    // RQ20 seven-bit character
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            char_bits <= 6'h00;
            parity_bit <= 1'b0;
        end else if (capture) begin
            char_bits <= in_data;
            parity_bit <= in_parity;
        end else if (precess_control) begin
            char_bits <= {char_bits[4:0], recirculated_bit};
            parity_bit <= parity_bit ^ recirculated_bit;
        end
    end

    // RQ18 serial write
    wire next_serial_write_bit = precess_control ? char_bits[CHAR_BITS-1]
        : (word_load ? accum_word[pulse < 5'h18 ? pulse : 5'h00]
                     : recirculated_bit);
    // RQ19 delay line
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            serial_write_bit <= 1'b0;
            delay_line <= 24'h000000;
            word_reg <= 24'h000000;
        end else begin
            serial_write_bit <= next_serial_write_bit;
            delay_line <= {delay_line[22:0], serial_write_bit};
            if (word_load) begin
                word_reg <= accum_word;
            end
        end
    end
    assign recirculated_bit = delay_line[WORD_BITS-1];

    // RQ16 time-share request
    assign timeshare_req = !interlock_flag && halt_enable && !halt_flag
        && interlace_on && participate;
    // RQ22 service interrupt
    assign service_irq = !interlock_flag && halt_enable && !halt_flag
        && irq_enable;
    // RQ23 terminate interrupt
    assign terminate_irq = !interlock_flag && halt_flag && irq_enable;
    assign word_out = word_reg;
    assign char_out = char_bits;
    assign char_parity_out = parity_bit;
    assign status = '{unit_address: unit_address,
                      direction_out: direction_out,
                      char_count: {char_count_hi, char_count_lo},
                      interlock_flag: interlock_flag,
                      halt_flag: halt_flag,
                      error: error,
                      halt_enable: halt_enable};

    // RQ5 counter step check
    chk_count_down: assert property ( // RQ5
        @(posedge sys_clk) disable iff (!resetn)
        precess_control && t0 && !manual_start_switch && !buffer_clear
        && !buffer_setup && !word_load && status.char_count != 2'h0
        |=> status.char_count == $past(status.char_count) - 2'h1)
        else $error("char count did not step");
    // RQ13 halt hold
    chk_halt_sticky: assert property ( // RQ13
        @(posedge sys_clk) disable iff (!resetn)
        halt_flag && !buffer_clear_cmd |=> halt_flag)
        else $error("halt dropped without clear");
    // RQ8 precess pulse
    chk_precess_short: assert property (@(posedge sys_clk) // RQ8
        disable iff (!resetn)
        precess_control && (t0 || t24) |=> !precess_control)
        else $error("precess not reset");
    // RQ19 delay exact
    chk_delay_line: assert property ( // RQ19
        @(posedge sys_clk) disable iff (!resetn)
        ##24 recirculated_bit == $past(serial_write_bit, 24))
        else $error("recirculation delay wrong");
    // RQ1 clear effect
    chk_clear_addr: assert property ( // RQ1
        @(posedge sys_clk) disable iff (!resetn)
        buffer_clear_cmd |=> unit_address == 5'h00 && !direction_out)
        else $error("clear left address");
    // RQ2 setup load
    chk_setup_load: assert property ( // RQ2
        @(posedge sys_clk) disable iff (!resetn)
        buffer_setup && !buffer_clear |=>
        unit_address == $past(instr_bits[23:19]))
        else $error("setup address wrong");
    // RQ16 request gating
    chk_ts_gate: assert property ( // RQ16
        @(posedge sys_clk) disable iff (!resetn)
        halt_flag |-> !timeshare_req && !service_irq)
        else $error("request during halt");
    // RQ17 grant flag
    chk_grant_flag: assert property ( // RQ17
        @(posedge sys_clk) disable iff (!resetn)
        memory_grant_flag |-> $past(memory_grant) && $past(participate))
        else $error("grant flag without grant");
    cov_precess: cover property (@(posedge sys_clk) disable iff (!resetn)
        precess_detect ##[1:30] precess_control);
    cov_halt: cover property (@(posedge sys_clk) disable iff (!resetn)
        terminate_irq);
    cov_error: cover property (@(posedge sys_clk) disable iff (!resetn)
        $rose(error));
endmodule // char_buffer_io_channel
`default_nettype wire

// >>> pkg/chbuf_pkg.sv
package chbuf_pkg;
    localparam int PULSES = 26;
    localparam logic [4:0] T0 = 5'h00;
    localparam logic [4:0] T5 = 5'h05;
    localparam logic [4:0] T17 = 5'h11;
    localparam logic [4:0] T22 = 5'h16;
    localparam logic [4:0] T24 = 5'h18;
    localparam logic [4:0] TP = 5'h19;
    localparam logic [4:0] PULSE_LAST = 5'h19;
    localparam int WORD_BITS = 24;
    localparam int CHAR_BITS = 6;
    localparam int ADDR_LSB = 19;
    localparam int DIR_BIT = 18;
    localparam int CNT_HI_BIT = 16;
    localparam int CNT_LO_BIT = 15;
    localparam int PRECESS_BIT = 13;
    localparam logic [1:0] CNT_FULL = 2'h3;
    localparam logic [4:0] READER_ADDR = 5'h04;

    typedef struct packed {
        logic [5:0] data;
        logic parity;
        logic clk;
        logic halt;
        logic tape_gap;
        logic tape_error;
    } unit_in_t;

    typedef struct packed {
        logic [4:0] unit_address;
        logic direction_out;
        logic [1:0] char_count;
        logic interlock_flag;
        logic halt_flag;
        logic error;
        logic halt_enable;
    } status_t;
endpackage

// >>> verification/char_unit_model.sv
`timescale 1ns/1ps
`default_nettype none
module char_unit_model (
    output logic unit_clk,
    output chbuf_pkg::unit_in_t unit_in
);
    import chbuf_pkg::*;

    initial begin
        unit_clk = 1'b0;
        unit_in = '0;
    end

    // The link clock runs only inside a frame and idles low between frames.
    // The odd start offset keeps its edges clear of the processor clock.
    task automatic run_link(input int periods);
        #37;
        repeat (periods) begin
            #80 unit_clk = 1'b1;
            #80 unit_clk = 1'b0;
        end
    endtask

    task automatic send_char(input logic [5:0] d, input logic bad);
        unit_in.data = d;
        unit_in.parity = ~(^d) ^ bad;
        unit_in.clk = 1'b1;
        run_link(20);
        unit_in.clk = 1'b0;
        run_link(20);
        // Released lines show the inverse so a stale character cannot pass.
        unit_in.data = ~d;
        unit_in.parity = ~unit_in.parity;
        run_link(4);
    endtask

    task automatic set_halt(input logic level);
        unit_in.halt = level;
        run_link(8);
    endtask
endmodule // char_unit_model
`default_nettype wire

// >>> verification/char_buffer_io_channel_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("Error at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module char_buffer_io_channel_test;
    import chbuf_pkg::*;
    logic sys_clk;
    logic resetn;
    wire logic unit_clk;
    wire unit_in_t unit_in;
    logic buffer_clear_cmd;
    logic buffer_setup;
    logic [23:0] instr_bits;
    logic word_xfer_cmd;
    logic [23:0] accum_word;
    logic interlace_on;
    logic participate_set;
    logic [23:0] word_out;
    logic memory_grant;
    logic irq_enable;
    logic manual_fill_switch;
    logic manual_start_switch;
    logic timeshare_req;
    logic memory_grant_flag;
    logic service_irq;
    logic terminate_irq;
    status_t status;
    int err_total = 0;
    int comparisons = 0;
    logic [7:0] setup_tbl [3] = '{8'haa, 8'h55, 8'hff};

    char_unit_model i_char_unit_model (.unit_clk(unit_clk), .unit_in(unit_in));

    char_buffer_io_channel i_char_buffer_io_channel (
        .sys_clk(sys_clk), .resetn(resetn), .unit_clk(unit_clk),
        .unit_in(unit_in), .buffer_clear_cmd(buffer_clear_cmd),
        .buffer_setup(buffer_setup), .instr_bits(instr_bits),
        .word_xfer_cmd(word_xfer_cmd), .accum_word(accum_word),
        .interlace_on(interlace_on), .participate_set(participate_set),
        .memory_grant(memory_grant), .irq_enable(irq_enable),
        .manual_fill_switch(manual_fill_switch),
        .manual_start_switch(manual_start_switch),
        .no_parity_input(1'b0), .word_out(word_out), .char_out(),
        .char_parity_out(), .recirculated_bit(),
        .timeshare_req(timeshare_req), .memory_grant_flag(memory_grant_flag),
        .service_irq(service_irq), .terminate_irq(terminate_irq),
        .status(status)
    );

    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Held over two pulse rounds so the clear window is surely covered.
    task automatic clear_buf();
        buffer_clear_cmd = 1'b1;
        cyc(2 * PULSES);
        buffer_clear_cmd = 1'b0;
        cyc(2);
    endtask

    task automatic setup(input logic [4:0] addr, input logic dir,
                         input logic [1:0] cnt);
        instr_bits = '0;
        instr_bits[ADDR_LSB +: 5] = addr;
        instr_bits[DIR_BIT] = dir;
        instr_bits[CNT_HI_BIT] = cnt[1];
        instr_bits[CNT_LO_BIT] = cnt[0];
        buffer_setup = 1'b1;
        cyc(1);
        buffer_setup = 1'b0;
        cyc(1);
    endtask

    task automatic finish_test();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        finish_test();
    end

    initial begin
        resetn = 1'b0;
        buffer_clear_cmd = 1'b0;
        buffer_setup = 1'b0;
        instr_bits = '0;
        word_xfer_cmd = 1'b0;
        accum_word = '0;
        interlace_on = 1'b0;
        participate_set = 1'b0;
        memory_grant = 1'b0;
        irq_enable = 1'b0;
        manual_fill_switch = 1'b0;
        manual_start_switch = 1'b0;
        cyc(8);
        resetn = 1'b1;
        cyc(2);
        `CHK(status, status_t'('0))
        for (int i = 0; i < 3; i++) begin
            clear_buf();
            setup(setup_tbl[i][7:3], setup_tbl[i][2], setup_tbl[i][1:0]);
            `CHK(status.unit_address, setup_tbl[i][7:3])
            `CHK(status.direction_out, setup_tbl[i][2])
            `CHK(status.char_count, setup_tbl[i][1:0])
            if (setup_tbl[i][2]) begin
                `CHK(status.interlock_flag, 1'b0)
                accum_word = 24'ha5c3f0;
                word_xfer_cmd = 1'b1;
                cyc(PULSES);
                word_xfer_cmd = 1'b0;
                cyc(2);
                `CHK(status.interlock_flag, 1'b1)
                `CHK(word_out, 24'ha5c3f0)
            end
        end
        clear_buf();
        `CHK(status.unit_address, 5'h00)
        `CHK(status.char_count, 2'h0)
        `CHK(status.direction_out, 1'b0)
        manual_fill_switch = 1'b1;
        cyc(2);
        manual_fill_switch = 1'b0;
        `CHK(status.unit_address, READER_ADDR)
        clear_buf();
        manual_start_switch = 1'b1;
        cyc(2);
        manual_start_switch = 1'b0;
        cyc(1);
        `CHK(status.char_count, CNT_FULL)
        memory_grant = 1'b1;
        cyc(3);
        `CHK(memory_grant_flag, 1'b0)
        // Participation stays on so that later clears re-arm interlace.
        participate_set = 1'b1;
        cyc(3);
        `CHK(memory_grant_flag, 1'b1)
        memory_grant = 1'b0;
        cyc(2);
        `CHK(memory_grant_flag, 1'b0)
        clear_buf();
        irq_enable = 1'b1;
        interlace_on = 1'b1;
        setup(5'h01, 1'b0, 2'h3);
        for (int i = 0; i < 3; i++) begin
            i_char_unit_model.send_char(6'h05 + 6'(i), 1'b0);
            cyc(3 * PULSES);
        end
        `CHK(status.error, 1'b0)
        i_char_unit_model.send_char(6'h2a, 1'b1);
        cyc(3 * PULSES);
        `CHK(status.error, 1'b1)
        `CHK(status.interlock_flag, 1'b0)
        `CHK(status.halt_enable, 1'b1)
        `CHK(service_irq, 1'b1)
        `CHK(timeshare_req, 1'b1)
        interlace_on = 1'b0;
        cyc(1);
        `CHK(timeshare_req, 1'b0)
        i_char_unit_model.set_halt(1'b1);
        cyc(2 * PULSES);
        `CHK(status.halt_flag, 1'b1)
        `CHK(terminate_irq, 1'b1)
        `CHK(service_irq, 1'b0)
        i_char_unit_model.set_halt(1'b0);
        cyc(2 * PULSES);
        `CHK(status.halt_flag, 1'b1)
        irq_enable = 1'b0;
        cyc(1);
        `CHK(terminate_irq, 1'b0)
        clear_buf();
        clear_buf();
        `CHK(status.halt_flag, 1'b0)
        `CHK(status.error, 1'b0)
        `CHK(status.interlock_flag, 1'b1)
        finish_test();
    end
endmodule // char_buffer_io_channel_test
`default_nettype wire
